// ### verification/psg_ecu_model.sv
// ecu fault logic model driving the kill pin and ground opens
`timescale 1ns/1ps
module psg_ecu_model
    import psg_pkg::*;
(
    // clock
    input  wire logic               clk_i,
    // fault commands from the bench
    input  wire logic               ecu_fault_i,
    input  wire logic [NUM_GND-1:0] gnd_cut_i,
    // pins toward the device
    output logic                    predriver_kill_n_o,
    output logic      [NUM_GND-1:0] gnd_open_o
);
    initial predriver_kill_n_o = 1'b1;
    initial gnd_open_o = '0;
    // ecu answers one cycle after it sees its own fault
    always @(posedge clk_i)
    begin
        predriver_kill_n_o <= ~ecu_fault_i;
        gnd_open_o         <= gnd_cut_i;
    end
endmodule : psg_ecu_model

// ### verification/psg_shutoff_tb.sv
// self-checking bench of the pre-driver shutoff gate
`timescale 1ns/1ps
module psg_shutoff_tb;
    import psg_pkg::*;
    localparam logic [31:0] ALL = {18'h0, 7'h7F, 7'h7F};
    localparam logic [31:0] OPT = {18'h0, 7'h50, 7'h50};
    logic               clk_i = 1'b0;
    logic               rst_b_i = 1'b0;
    logic               ecu_fault = 1'b0;
    logic [NUM_GND-1:0] gnd_cut = '0;
    logic               predriver_kill_n;
    logic [NUM_GND-1:0] gnd_open;
    logic [NUM_DRV-1:0] hs_req_i = '0;
    logic [NUM_DRV-1:0] ls_req_i = '0;
    logic [NUM_DRV-1:0] hs_drv_o;
    logic [NUM_DRV-1:0] ls_drv_o;
    logic               supply_fault_flag_o;
    logic [AW-1:0]      avs_address_i = '0;
    logic               avs_read_i = 1'b0;
    logic               avs_write_i = 1'b0;
    logic [DW-1:0]      avs_writedata_i = '0;
    logic [DW-1:0]      avs_readdata_o;
    logic               avs_waitrequest_o;
    logic               irq_o;
    logic [31:0]        drv_w;
    int                 n_fail = 0;
    int                 samples_checked = 0;

    assign drv_w = {18'h0, hs_drv_o, ls_drv_o};
    always #20 clk_i = ~clk_i;

    psg_ecu_model ecu_u (.clk_i(clk_i), .ecu_fault_i(ecu_fault),
        .gnd_cut_i(gnd_cut), .predriver_kill_n_o(predriver_kill_n),
        .gnd_open_o(gnd_open));
    psg_shutoff dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .predriver_kill_n_i(predriver_kill_n), .gnd_open_i(gnd_open),
        .hs_req_i(hs_req_i), .ls_req_i(ls_req_i), .hs_drv_o(hs_drv_o),
        .ls_drv_o(ls_drv_o), .supply_fault_flag_o(supply_fault_flag_o),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));

    task automatic finish_test(input bit tmo);
        if (tmo)
            n_fail++;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_i);
            if (avs_waitrequest_o === 1'b0)
                break;
        end
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (i == 20)
            finish_test(1'b1);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd

    task automatic t_reset;
        chk({29'h0, supply_fault_flag_o, irq_o, avs_waitrequest_o}, 32'h1);
        chk(drv_w, 32'h0);
        rd(OFS_GATE_CFG, {28'h0, CFG_RESET});
        rd(OFS_EVT_ENABLE, 32'h0);
        rd(OFS_STATUS, 32'h1);
        rd(OFS_EVT_STATUS, 32'h0);
        wr(8'h40, 32'hF);
        rd(8'h40, 32'h0);
        rd(OFS_EVT_CLEAR, 32'h0);
        rd(OFS_GATE_CFG, 32'h0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_direct;
        hs_req_i <= 7'h7F;
        ls_req_i <= 7'h7F;
        tick(2);
        chk(drv_w, ALL);
        ecu_fault <= 1'b1;
        tick(1);
        #1;
        chk(drv_w, OPT);
        tick(4);
        chk(drv_w, OPT);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_EVT_STATUS, 32'h1);
        ecu_fault <= 1'b0;
        tick(5);
        chk(drv_w, ALL);
        $display("direct path test done");
    endtask : t_direct

    task automatic t_gated;
        logic [3:0] c;
        wr(OFS_EVT_ENABLE, 32'h1);
        rd(OFS_EVT_ENABLE, 32'h1);
        tick(2);
        chk({31'h0, irq_o}, 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            c = 4'h1 << k;
            wr(OFS_GATE_CFG, {28'h0, c});
            rd(OFS_GATE_CFG, {28'h0, c});
            wr(OFS_EVT_CLEAR, 32'h1);
            tick(2);
            chk({31'h0, irq_o}, 32'h0);
            ecu_fault <= 1'b1;
            tick(6);
            chk(drv_w, {18'h0, ~c[1], 1'b0, ~c[0], 4'h0,
                        ~c[3], 1'b0, ~c[2], 4'h0});
            chk({31'h0, irq_o}, 32'h1);
            ecu_fault <= 1'b0;
            tick(5);
            chk(drv_w, ALL);
        end
        wr(OFS_EVT_CLEAR, 32'h1);
        rd(OFS_EVT_STATUS, 32'h0);
        $display("gated path test done");
    endtask : t_gated

    task automatic t_gnd;
        logic [2:0] pats [7] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h6, 3'h5, 3'h7};
        int i;
        for (int k = 0; k < 7; k++)
        begin
            gnd_cut <= pats[k];
            tick(GND_FILTER_CYC - 5);
            chk(drv_w, ALL);
            for (i = 0; i < 30 && supply_fault_flag_o !== 1'b1; i++)
                tick(1);
            if (k < 6 && i == 30)
                finish_test(1'b1);
            chk({31'h0, supply_fault_flag_o}, {31'h0, k < 6});
            chk(drv_w, k < 6 ? 32'h0 : ALL);
            gnd_cut <= '0;
            tick(6);
            chk(drv_w, ALL);
            chk({31'h0, supply_fault_flag_o}, 32'h0);
        end
        rd(OFS_EVT_STATUS, 32'h2);
        chk({31'h0, irq_o}, 32'h0);
        wr(OFS_EVT_ENABLE, 32'h3);
        tick(2);
        chk({31'h0, irq_o}, 32'h1);
        wr(OFS_EVT_CLEAR, 32'h3);
        tick(2);
        chk({31'h0, irq_o}, 32'h0);
        $display("ground loss test done");
    endtask : t_gnd

    initial
    begin
        tick(3);
        rst_b_i <= 1'b1;
        tick(6);
        t_reset();
        t_direct();
        t_gated();
        t_gnd();
        finish_test(1'b0);
    end
endmodule : psg_shutoff_tb

// ### verilog/psg_gnd_filter.sv
// ground loss filter that raises the supply fault flag
`timescale 1ns/1ps
module psg_gnd_filter
    import psg_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // detection
    input  wire logic loss_i,
    output logic      fault_o
);
    localparam logic [FILT_CW-1:0] LAST = FILT_CW'(GND_FILTER_CYC - 1);

    typedef struct packed {
        logic [FILT_CW-1:0] cnt;
        logic               fault;
    } psg_filt_t;

    psg_filt_t st_reg;
    psg_filt_t st_next;

    always_comb
    begin
        st_next = st_reg;
        if (!loss_i)
        begin
            st_next.cnt   = '0;
            st_next.fault = 1'b0;
        end
        else if (st_reg.cnt == LAST)
            st_next.fault = 1'b1;
        else
            st_next.cnt = st_reg.cnt + FILT_CW'(1);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign fault_o = st_reg.fault;

    chk_filter_hold_time: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(st_reg.fault) |-> $past(st_reg.cnt) == LAST && $past(loss_i))
        else $error("fault raised before filter interval");
    chk_filter_release: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !loss_i |=> !st_reg.fault && st_reg.cnt == '0)
        else $error("fault held without ground loss");
endmodule : psg_gnd_filter

// ### verilog/psg_pkg.sv
// constants, register map and field layout of the pre-driver shutoff gate
package psg_pkg;
    localparam int unsigned  CLK_HZ          = 25000000;
    localparam int unsigned  NUM_DRV         = 7;
    localparam int unsigned  NUM_GND         = 3;
    localparam int unsigned  AW              = 8;
    localparam int unsigned  DW              = 32;

    // ground loss filter interval, ns, and derived cycles (rounded up)
    localparam int unsigned  GND_FILTER_NS   = 10000;
    localparam int unsigned  GND_FILTER_CYC  =
        (GND_FILTER_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned  FILT_CW         = 12;

    // register byte offsets
    localparam logic [7:0]   OFS_GATE_CFG    = 8'h00;
    localparam logic [7:0]   OFS_STATUS      = 8'h04;
    localparam logic [7:0]   OFS_EVT_STATUS  = 8'h08;
    localparam logic [7:0]   OFS_EVT_CLEAR   = 8'h0C;
    localparam logic [7:0]   OFS_EVT_ENABLE  = 8'h10;

    // gate configuration bits
    localparam int unsigned  CFG_HS_FIVE     = 0;
    localparam int unsigned  CFG_HS_SEVEN    = 1;
    localparam int unsigned  CFG_LS_FIVE     = 2;
    localparam int unsigned  CFG_LS_SEVEN    = 3;
    localparam int unsigned  CFG_W           = 4;
    localparam logic [3:0]   CFG_RESET       = 4'h0;

    // status bits
    localparam int unsigned  ST_KILL_LEVEL   = 0;
    localparam int unsigned  ST_FAULT        = 1;
    localparam int unsigned  ST_GND_LOSS     = 2;

    // event bits
    localparam int unsigned  EV_KILL         = 0;
    localparam int unsigned  EV_FAULT        = 1;
    localparam int unsigned  EV_W            = 2;
    localparam logic [1:0]   EV_RESET        = 2'h0;

    // driver index of drivers five and seven
    localparam int unsigned  IDX_FIVE        = 4;
    localparam int unsigned  IDX_SEVEN       = 6;
    // drivers one to four and six are wired straight to the pin
    localparam logic [6:0]   DIRECT_MASK     = 7'h2F;
endpackage : psg_pkg

// ### verilog/psg_shutoff.sv
// pre-driver shutoff gate with avalon register slave
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - ground loss raises supply fault flag and turns every pre-driver off.
// - ground loss passes a filter interval before the fault flag acts.
// - any one or two of three grounds open is a ground loss.
// - negated kill pin turns off every driver without a gating option.
// - kill pin level is readable in a status register.
// - high-side one to four and six cut by direct pin path.
// - low-side one to four and six cut by direct pin path.
// - drivers five and seven are gated by the kill pin through core only.
// - direct path works without clock or core; driver defaults off.
module psg_shutoff
    import psg_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    // pins and analog indications
    input  wire logic                  predriver_kill_n_i,
    input  wire logic [NUM_GND-1:0]    gnd_open_i,
    // driver requests from the actuator logic
    input  wire logic [NUM_DRV-1:0]    hs_req_i,
    input  wire logic [NUM_DRV-1:0]    ls_req_i,
    // pre-driver enables and supply fault flag
    output logic      [NUM_DRV-1:0]    hs_drv_o,
    output logic      [NUM_DRV-1:0]    ls_drv_o,
    output logic                       supply_fault_flag_o,
    // avalon-mm slave
    input  wire logic [psg_pkg::AW-1:0] avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [psg_pkg::DW-1:0] avs_writedata_i,
    output logic      [psg_pkg::DW-1:0] avs_readdata_o,
    output logic                       avs_waitrequest_o,
    // interrupt
    output logic                       irq_o
);
    import psg_pkg::*;

    typedef struct packed {
        logic              waitreq;
        logic [DW-1:0]     rdata;
        logic [CFG_W-1:0]  cfg;
        logic [EV_W-1:0]   ev_st;
        logic [EV_W-1:0]   ev_en;
        logic              irq;
        logic [NUM_DRV-1:0] core_hs;
        logic [NUM_DRV-1:0] core_ls;
        logic              kill_prev;
        logic              fault_prev;
    } psg_state_t;

    psg_state_t st_reg;
    psg_state_t st_next;

    logic              rst_meta_reg;
    logic              rst_n;
    logic              kill_sync;
    logic [NUM_GND-1:0] open_sync;
    logic              gnd_loss;
    logic              fault;
    logic              req_new;
    logic              gate_hs5;
    logic              gate_hs7;
    logic              gate_ls5;
    logic              gate_ls7;
    logic [NUM_DRV-1:0] opt_off_hs;
    logic [NUM_DRV-1:0] opt_off_ls;
    logic [EV_W-1:0]   ev_set;
    logic [EV_W-1:0]   ev_clr;

    // reset release through two flip-flops
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    psg_sync2 #(
        .W (1 + NUM_GND)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .async_i ({predriver_kill_n_i, gnd_open_i}),
        .sync_o  ({kill_sync, open_sync})
    );

    // loss only detectable while one ground still holds
    assign gnd_loss = (|open_sync) && !(&open_sync);

    psg_gnd_filter u_filter (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .loss_i  (gnd_loss),
        .fault_o (fault)
    );

    assign gate_hs5 = st_reg.cfg[CFG_HS_FIVE]  && !kill_sync;
    assign gate_hs7 = st_reg.cfg[CFG_HS_SEVEN] && !kill_sync;
    assign gate_ls5 = st_reg.cfg[CFG_LS_FIVE]  && !kill_sync;
    assign gate_ls7 = st_reg.cfg[CFG_LS_SEVEN] && !kill_sync;

    // optional drivers gated by the core only
    always_comb
    begin
        opt_off_hs            = '0;
        opt_off_ls            = '0;
        opt_off_hs[IDX_FIVE]  = gate_hs5;
        opt_off_hs[IDX_SEVEN] = gate_hs7;
        opt_off_ls[IDX_FIVE]  = gate_ls5;
        opt_off_ls[IDX_SEVEN] = gate_ls7;
    end

    assign req_new = (avs_read_i || avs_write_i) && st_reg.waitreq;
    assign ev_set  = {fault && !st_reg.fault_prev,
                      !kill_sync && st_reg.kill_prev};
    assign ev_clr  = (avs_write_i && !st_reg.waitreq &&
                      avs_address_i == OFS_EVT_CLEAR) ?
                     avs_writedata_i[EV_W-1:0] : '0;

    always_comb
    begin
        st_next            = st_reg;
        st_next.kill_prev  = kill_sync;
        st_next.fault_prev = fault;
        // core decision, fault overrides all requests
        st_next.core_hs = fault ? '0 : hs_req_i & ~opt_off_hs;
        st_next.core_ls = fault ? '0 : ls_req_i & ~opt_off_ls;
        // one wait cycle, answer on the next edge
        st_next.waitreq = !req_new;
        if (req_new && avs_read_i)
        begin
            case (avs_address_i)
                OFS_GATE_CFG:   st_next.rdata = DW'(st_reg.cfg);
                OFS_STATUS:     st_next.rdata =
                    DW'({gnd_loss, fault, kill_sync});
                OFS_EVT_STATUS: st_next.rdata = DW'(st_reg.ev_st);
                OFS_EVT_ENABLE: st_next.rdata = DW'(st_reg.ev_en);
                default:        st_next.rdata = '0;
            endcase
        end
        if (avs_write_i && !st_reg.waitreq)
        begin
            case (avs_address_i)
                OFS_GATE_CFG:   st_next.cfg   = avs_writedata_i[CFG_W-1:0];
                OFS_EVT_ENABLE: st_next.ev_en = avs_writedata_i[EV_W-1:0];
                default:        st_next.cfg   = st_reg.cfg;
            endcase
        end
        // set wins over clear
        st_next.ev_st = (st_reg.ev_st & ~ev_clr) | ev_set;
        st_next.irq   = |(st_next.ev_st & st_next.ev_en);
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg           <= '0;
            st_reg.waitreq   <= 1'b1;
            st_reg.cfg       <= CFG_RESET;
            st_reg.ev_st     <= EV_RESET;
            st_reg.ev_en     <= EV_RESET;
            // matches the kill synchroniser's reset level: no false event
            st_reg.kill_prev <= 1'b0;
        end
        else
            st_reg <= st_next;
    end

    // direct pin path: raw kill pin gates drivers, no clock involved
    for (genvar i = 0; i < NUM_DRV; i++)
    begin : g_drv
        if (DIRECT_MASK[i])
        begin : g_direct
            assign hs_drv_o[i] = st_reg.core_hs[i] &&
                                 predriver_kill_n_i;
            assign ls_drv_o[i] = st_reg.core_ls[i] &&
                                 predriver_kill_n_i;
        end
        else
        begin : g_core
            assign hs_drv_o[i] = st_reg.core_hs[i];
            assign ls_drv_o[i] = st_reg.core_ls[i];
        end
    end

    assign supply_fault_flag_o = st_reg.fault_prev;
    assign avs_readdata_o      = st_reg.rdata;
    assign avs_waitrequest_o   = st_reg.waitreq;
    assign irq_o               = st_reg.irq;

    chk_fault_hs_off: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        fault |=> hs_drv_o == '0 && ls_drv_o == '0)
        else $error("driver on during supply fault");
    chk_fault_no_rise: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        supply_fault_flag_o |-> !$rose(|{hs_drv_o, ls_drv_o}))
        else $error("driver rose while fault flagged");
    chk_direct_hs_off: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !predriver_kill_n_i |-> (hs_drv_o & DIRECT_MASK) == '0)
        else $error("direct high side on with kill negated");
    chk_direct_ls_off: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !predriver_kill_n_i |-> (ls_drv_o & DIRECT_MASK) == '0)
        else $error("direct low side on with kill negated");
    chk_opt_gate_hs5: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        st_reg.cfg[CFG_HS_FIVE] && !kill_sync |=> !hs_drv_o[IDX_FIVE])
        else $error("gated driver five stayed on");
    chk_opt_pass_ls7: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !st_reg.cfg[CFG_LS_SEVEN] && !fault && ls_req_i[IDX_SEVEN]
        |=> ls_drv_o[IDX_SEVEN])
        else $error("ungated driver seven was cut");
    chk_kill_readback: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        req_new && avs_read_i && avs_address_i == OFS_STATUS
        |=> avs_readdata_o[ST_KILL_LEVEL] == $past(kill_sync))
        else $error("kill level readback wrong");
    chk_gnd_loss_set: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        gnd_loss [*8] |-> ##[0:300] fault || !gnd_loss)
        else $error("ground loss did not raise fault");
    chk_wait_one: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        req_new |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("waitrequest not one cycle");
    chk_irq_level: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ##1 irq_o == |($past(st_next.ev_st) & $past(st_next.ev_en)))
        else $error("interrupt level wrong");
    chk_opt_gate_hs7: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        st_reg.cfg[CFG_HS_SEVEN] && !kill_sync |=> !hs_drv_o[IDX_SEVEN])
        else $error("gated high side seven stayed on");
    chk_opt_gate_ls5: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        st_reg.cfg[CFG_LS_FIVE] && !kill_sync |=> !ls_drv_o[IDX_FIVE])
        else $error("gated low side five stayed on");
    chk_opt_gate_ls7: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        st_reg.cfg[CFG_LS_SEVEN] && !kill_sync |=> !ls_drv_o[IDX_SEVEN])
        else $error("gated low side seven stayed on");
    chk_opt_pass_hs5: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !st_reg.cfg[CFG_HS_FIVE] && !fault && hs_req_i[IDX_FIVE]
        |=> hs_drv_o[IDX_FIVE])
        else $error("ungated high side five was cut");
    chk_direct_pass_hs: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        hs_req_i[0] && !fault |=> hs_drv_o[0] == predriver_kill_n_i)
        else $error("direct high side one not following pin");
    chk_direct_pass_ls: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ls_req_i[0] && !fault |=> ls_drv_o[0] == predriver_kill_n_i)
        else $error("direct low side one not following pin");
    chk_flag_follows: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        fault |=> supply_fault_flag_o)
        else $error("supply fault flag missed the fault");
    chk_all_open_none: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        &open_sync |=> !fault)
        else $error("fault raised with every ground open");
    chk_kill_event: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        $fell(kill_sync) |=> st_reg.ev_st[EV_KILL])
        else $error("kill event not recorded");
    chk_event_sticky: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        st_reg.ev_st[EV_FAULT] && !ev_clr[EV_FAULT]
        |=> st_reg.ev_st[EV_FAULT])
        else $error("fault event lost without clear");
    chk_set_over_clr: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ev_set[EV_FAULT] |=> st_reg.ev_st[EV_FAULT])
        else $error("fault event set did not win");
    chk_cfg_write: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        avs_write_i && !st_reg.waitreq && avs_address_i == OFS_GATE_CFG
        |=> st_reg.cfg == $past(avs_writedata_i[CFG_W-1:0]))
        else $error("gate configuration write lost");
    chk_clear_reads_zero: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        req_new && avs_read_i && avs_address_i == OFS_EVT_CLEAR
        |=> avs_readdata_o == '0)
        else $error("event clear register read not zero");
    chk_idle_wait_high: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !avs_read_i && !avs_write_i |=> avs_waitrequest_o)
        else $error("waitrequest low while idle");
    chk_rdata_hold: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        !(req_new && avs_read_i) |=> $stable(avs_readdata_o))
        else $error("read data changed without a read");
endmodule : psg_shutoff

// ### verilog/psg_sync2.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module psg_sync2 #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } psg_sync_t;

    psg_sync_t st_reg;
    psg_sync_t st_next;

    always_comb
    begin
        st_next.meta = async_i;
        st_next.sync = st_reg.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign sync_o = st_reg.sync;
endmodule : psg_sync2
